// ### rtl/cmd_pkg.sv
// constants, types and command codes of the recorder command handler
//
// What this block does
// - trigger character starts or stops per trigger configuration
// - trigger character without command triggering raises error
// - deferred commands wait for the execute command
// - immediate commands act right after parsing
// - buffer flush discards every held sample
// - buffer overrun reported as poll bit 128
// - channel clear stops readings until reconfigured
// - factory restore loads default working configuration
// - factory restore refused while acquisition configured
// - factory restore keeps calibration factors untouched
// - new keyword must be five decimal digits
// - calibration entry only on keyword match
// - keyword change only with protection disabled
// - source select: 01 negative, 02 positive, 03 ground
// - source select holds sequencer, no other switching
package cmd_pkg;

  // ****************************************************************
  // command codes from the parser
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_TRIG      = 4'h1,
    CMD_FLUSH     = 4'h2,
    CMD_CLR_CHAN  = 4'h3,
    CMD_FACTORY   = 4'h4,
    CMD_KEYWORD   = 4'h5,
    CMD_CAL_SRC   = 4'h6,
    CMD_EXECUTE   = 4'h7,
    CMD_CAL_ENTER = 4'h8,
    CMD_CAL_EXIT  = 4'h9,
    CMD_CHAN_CFG  = 4'hA
  } cmd_code_e;

  typedef enum logic [0:0] {
    ACQ_IDLE = 1'b0,
    ACQ_RUN  = 1'b1
  } acq_state_e;

  // ****************************************************************
  // widths, fields and reset values
  // ****************************************************************
  localparam int unsigned KEY_DIGITS   = 5;
  localparam int unsigned KEY_W        = 4 * KEY_DIGITS;
  localparam int unsigned BUF_DEPTH    = 1024;
  localparam int unsigned BUF_CNT_W    = 11;
  localparam logic [KEY_W-1:0] KEY_RESET = 20'h00000;

  localparam logic [7:0] SRC_NEG_ARG = 8'h01;
  localparam logic [7:0] SRC_POS_ARG = 8'h02;
  localparam logic [7:0] SRC_GND_ARG = 8'h03;

  localparam int unsigned POLL_OVR_B   = 7;  // weight 128
  localparam int unsigned CAL_KW_ERR_B = 4;  // weight 16

  localparam int unsigned ERR_TRIG_B     = 0;
  localparam int unsigned ERR_CONFLICT_B = 1;
  localparam int unsigned ERR_KEY_FMT_B  = 2;
  localparam int unsigned ERR_PROTECT_B  = 3;
  localparam int unsigned ERR_SRC_ARG_B  = 4;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic             valid;
    cmd_code_e        code;
    logic [KEY_W-1:0] arg;
  } cmd_s;

  typedef struct packed {
    logic       trig_start_cmd;
    logic       trig_stop_cmd;
    logic [7:0] avg_weight;
    logic [7:0] user_term;
  } cfg_s;

  localparam cfg_s CFG_DEFAULT = '{1'b0, 1'b0, 8'h20, 8'h0A};

  typedef struct packed {
    logic src_neg;
    logic src_pos;
    logic src_gnd;
    logic seq_hold;
  } cal_src_s;

endpackage : cmd_pkg

// ### rtl/pin_sync.sv
// two-flop synchroniser for a level from a pin
`timescale 1ns/100ps
module pin_sync
  import cmd_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level in and out
  input  wire logic pin_in,
  output logic      sync_out
);
  import cmd_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_st_s;

  sync_st_s st_r;
  sync_st_s st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pin_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.sync;

endmodule : pin_sync

// ### rtl/key_store.sv
// stored calibration keyword with format check and compare
`timescale 1ns/100ps
module key_store
  import cmd_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // store and compare
  input  wire logic             store,
  input  wire logic [KEY_W-1:0] key_in,
  output logic                  fmt_ok,
  output logic                  match
);
  import cmd_pkg::*;

  typedef struct packed {
    logic [KEY_W-1:0] key;
  } key_st_s;

  key_st_s                 st_r;
  key_st_s                 st_nxt;
  logic [KEY_DIGITS-1:0]   digit_ok;

  // ****************************************************************
  // decimal digit check
  // ****************************************************************
  for (genvar d = 0; d < KEY_DIGITS; d++) begin : g_digit
    assign digit_ok[d] = (key_in[4*d +: 4] <= 4'h9);
  end

  assign fmt_ok = &digit_ok;
  assign match  = (key_in == st_r.key);

  always_comb begin
    st_nxt = st_r;
    if (store && fmt_ok) begin
      st_nxt.key = key_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '{KEY_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : key_store

// ### rtl/cmd_handler.sv
// command handler: deferred and immediate commands, buffer, calibration
`timescale 1ns/100ps
module cmd_handler
  import cmd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // parsed commands
  input  wire cmd_pkg::cmd_s     cmd_in,
  // working configuration writes and acquisition status
  input  wire logic              cfg_wr,
  input  wire cmd_pkg::cfg_s     cfg_in,
  input  wire logic              acq_configured,
  // acquisition buffer traffic
  input  wire logic              buf_wr,
  input  wire logic              buf_rd,
  // calibration protection switch pin, high while protected
  input  wire logic              cal_protect_pin,
  // error flag clear
  input  wire logic              err_clr,
  // acquisition and channel control
  output logic                   trig_start_p,
  output logic                   trig_stop_p,
  output logic                   acq_running,
  output logic                   chan_configured,
  output logic                   high_low_last_values_en,
  output logic                   buf_flush_p,
  output logic [BUF_CNT_W-1:0]   buf_count,
  output logic [7:0]             poll_byte,
  // configuration
  output cmd_pkg::cfg_s          cfg_out,
  // calibration
  output logic                   cal_mode,
  output logic [7:0]             cal_status,
  output cmd_pkg::cal_src_s      cal_src,
  // errors
  output logic [7:0]             err_flags
);
  import cmd_pkg::*;

  typedef struct packed {
    acq_state_e           acq;
    logic                 pend_trig;
    logic                 pend_clr;
    logic                 start_p;
    logic                 stop_p;
    logic                 chan_cfg;
    logic                 flush_p;
    logic [BUF_CNT_W-1:0] count;
    logic                 overrun;
    logic [7:0]           poll;
    cfg_s                 cfg;
    logic                 cal_mode;
    logic [7:0]           cal_stat;
    cal_src_s             src;
    logic [7:0]           err;
  } hdl_st_s;

  hdl_st_s st_r;
  hdl_st_s st_nxt;
  logic    protect_on;
  logic    key_fmt_ok;
  logic    key_match;
  logic    is_cmd;
  logic    exec;
  logic    key_store_en;

  // ****************************************************************
  // helpers
  // ****************************************************************
  pin_sync u_prot_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (cal_protect_pin),
    .sync_out (protect_on)
  );

  assign is_cmd       = cmd_in.valid;
  assign exec         = is_cmd && (cmd_in.code == CMD_EXECUTE);
  assign key_store_en = is_cmd && (cmd_in.code == CMD_KEYWORD) && !protect_on;

  key_store u_key (
    .clk    (clk),
    .rst_n  (rst_n),
    .store  (key_store_en),
    .key_in (cmd_in.arg),
    .fmt_ok (key_fmt_ok),
    .match  (key_match)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt         = st_r;
    st_nxt.start_p = 1'b0;
    st_nxt.stop_p  = 1'b0;
    st_nxt.flush_p = 1'b0;
    // errors clear first so a same-cycle event still sets
    if (err_clr) begin
      st_nxt.err = '0;
    end
    if (cfg_wr) begin
      st_nxt.cfg = cfg_in;
    end
    // buffer occupancy; overrun on write into a full buffer
    if (buf_wr && !buf_rd) begin
      if (st_r.count == BUF_CNT_W'(BUF_DEPTH)) begin
        st_nxt.overrun = 1'b1;
      end else begin
        st_nxt.count = st_r.count + 1'b1;
      end
    end else if (buf_rd && !buf_wr && (st_r.count != '0)) begin
      st_nxt.count = st_r.count - 1'b1;
    end
    // unconfigured channels write nothing, so no overrun either
    if (!st_r.chan_cfg) begin
      st_nxt.count   = st_r.count;
      st_nxt.overrun = st_r.overrun;
    end
    if (is_cmd) begin
      case (cmd_in.code)
        CMD_TRIG: begin
          if (st_r.cfg.trig_start_cmd || st_r.cfg.trig_stop_cmd) begin
            st_nxt.pend_trig = 1'b1;
          end else begin
            st_nxt.err[ERR_TRIG_B] = 1'b1;
          end
        end
        CMD_CLR_CHAN: begin
          st_nxt.pend_clr = 1'b1;
        end
        CMD_CHAN_CFG: begin
          st_nxt.chan_cfg = 1'b1;
        end
        CMD_FLUSH: begin
          st_nxt.count   = '0;
          st_nxt.overrun = 1'b0;
          st_nxt.flush_p = 1'b1;
        end
        CMD_FACTORY: begin
          if (acq_configured) begin
            st_nxt.err[ERR_CONFLICT_B] = 1'b1;
          end else begin
            // calibration factors live elsewhere and are not touched
            st_nxt.cfg = CFG_DEFAULT;
          end
        end
        CMD_KEYWORD: begin
          if (protect_on) begin
            st_nxt.err[ERR_PROTECT_B] = 1'b1;
          end else if (!key_fmt_ok) begin
            st_nxt.err[ERR_KEY_FMT_B] = 1'b1;
          end
        end
        CMD_CAL_ENTER: begin
          if (key_match) begin
            st_nxt.cal_mode = 1'b1;
          end else begin
            st_nxt.cal_stat[CAL_KW_ERR_B] = 1'b1;
          end
        end
        CMD_CAL_EXIT: begin
          st_nxt.cal_mode = 1'b0;
          st_nxt.cal_stat = '0;
          st_nxt.src      = '0;
        end
        CMD_CAL_SRC: begin
          // sequencer just sits; no address, sensor or relay activity
          case (cmd_in.arg[7:0])
            SRC_NEG_ARG: st_nxt.src = '{1'b1, 1'b0, 1'b0, 1'b1};
            SRC_POS_ARG: st_nxt.src = '{1'b0, 1'b1, 1'b0, 1'b1};
            SRC_GND_ARG: st_nxt.src = '{1'b0, 1'b0, 1'b1, 1'b1};
            default: st_nxt.err[ERR_SRC_ARG_B] = 1'b1;
          endcase
        end
        CMD_EXECUTE: begin
          st_nxt.pend_trig = 1'b0;
          st_nxt.pend_clr  = 1'b0;
          if (st_r.pend_clr) begin
            st_nxt.chan_cfg = 1'b0;
          end
          if (st_r.pend_trig) begin
            case (st_r.acq)
              ACQ_IDLE: begin
                if (st_r.cfg.trig_start_cmd) begin
                  st_nxt.acq     = ACQ_RUN;
                  st_nxt.start_p = 1'b1;
                end
              end
              ACQ_RUN: begin
                if (st_r.cfg.trig_stop_cmd) begin
                  st_nxt.acq    = ACQ_IDLE;
                  st_nxt.stop_p = 1'b1;
                end
              end
              default: st_nxt.acq = ACQ_IDLE;
            endcase
          end
        end
        default: ;
      endcase
    end
    st_nxt.poll             = 8'h00;
    st_nxt.poll[POLL_OVR_B] = st_nxt.overrun;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.acq      <= ACQ_IDLE;
      st_r.cfg      <= CFG_DEFAULT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign trig_start_p            = st_r.start_p;
  assign trig_stop_p             = st_r.stop_p;
  assign acq_running             = (st_r.acq == ACQ_RUN);
  assign chan_configured         = st_r.chan_cfg;
  assign high_low_last_values_en = st_r.chan_cfg;
  assign buf_flush_p             = st_r.flush_p;
  assign buf_count               = st_r.count;
  assign poll_byte               = st_r.poll;
  assign cfg_out                 = st_r.cfg;
  assign cal_mode                = st_r.cal_mode;
  assign cal_status              = st_r.cal_stat;
  assign cal_src                 = st_r.src;
  assign err_flags               = st_r.err;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_trig_parsed;
    is_cmd && (cmd_in.code == CMD_TRIG) && st_r.cfg.trig_start_cmd && !acq_running;
  endsequence

  sequence s_no_exec2;
    (!exec)[*2];
  endsequence

  a_trig_deferred: assert property (@(posedge clk) disable iff (!rst_n)
    s_trig_parsed ##1 s_no_exec2 |=> !trig_start_p && !acq_running)
    else $error("trigger ran without execute");

  a_trig_start: assert property (@(posedge clk) disable iff (!rst_n)
    exec && st_r.pend_trig && !acq_running && st_r.cfg.trig_start_cmd
    |=> trig_start_p ##1 (acq_running && !trig_start_p))
    else $error("execute did not start acquisition");

  a_trig_err: assert property (@(posedge clk) disable iff (!rst_n)
    is_cmd && (cmd_in.code == CMD_TRIG) && !st_r.cfg.trig_start_cmd
    && !st_r.cfg.trig_stop_cmd |=> err_flags[ERR_TRIG_B] && !st_r.pend_trig)
    else $error("trigger without command triggering not flagged");

  a_flush_empty: assert property (@(posedge clk) disable iff (!rst_n)
    is_cmd && (cmd_in.code == CMD_FLUSH) |=> (buf_count == '0) && buf_flush_p
    && !poll_byte[POLL_OVR_B])
    else $error("flush left data in buffer");

  a_overrun_bit: assert property (@(posedge clk) disable iff (!rst_n)
    buf_wr && !buf_rd && chan_configured && (buf_count == BUF_CNT_W'(BUF_DEPTH))
    && !(is_cmd && cmd_in.code == CMD_FLUSH) |=> poll_byte == 8'h80)
    else $error("overrun not shown in poll byte");

  a_clear_chan: assert property (@(posedge clk) disable iff (!rst_n)
    exec && st_r.pend_clr |=> !chan_configured && !high_low_last_values_en
    ##1 (buf_count == $past(buf_count)))
    else $error("channel clear did not stop updates");

  a_factory_conflict: assert property (@(posedge clk) disable iff (!rst_n)
    is_cmd && (cmd_in.code == CMD_FACTORY) && acq_configured && !cfg_wr
    |=> err_flags[ERR_CONFLICT_B] && (cfg_out == $past(cfg_out)))
    else $error("factory restore not refused");

  a_factory_load: assert property (@(posedge clk) disable iff (!rst_n)
    is_cmd && (cmd_in.code == CMD_FACTORY) && !acq_configured |=> cfg_out == CFG_DEFAULT)
    else $error("factory restore did not load defaults");

  a_key_protect: assert property (@(posedge clk) disable iff (!rst_n)
    is_cmd && (cmd_in.code == CMD_KEYWORD) && protect_on |=> err_flags[ERR_PROTECT_B])
    else $error("keyword change accepted while protected");

  a_kw_mismatch: assert property (@(posedge clk) disable iff (!rst_n)
    is_cmd && (cmd_in.code == CMD_CAL_ENTER) && !key_match && !cal_mode
    |=> cal_status[CAL_KW_ERR_B] && !cal_mode)
    else $error("keyword mismatch let calibration in");

  a_src_select: assert property (@(posedge clk) disable iff (!rst_n)
    is_cmd && (cmd_in.code == CMD_CAL_SRC) && (cmd_in.arg[7:0] == SRC_POS_ARG)
    |=> cal_src.src_pos && !cal_src.src_neg && !cal_src.src_gnd && cal_src.seq_hold)
    else $error("source select decoded wrongly");

endmodule : cmd_handler

// ### tb/host_ctrl_model.sv
// host controller model: issues parsed commands one cycle at a time
`timescale 1ns/100ps
module host_ctrl_model (
  // clock
  input  wire logic    clk,
  // command stream to the handler
  output cmd_pkg::cmd_s cmd
);
  import cmd_pkg::*;

  initial cmd = '0;

  // keyword as five decimal digits, digit0 lowest
  function automatic logic [KEY_W-1:0] key_bcd(input int unsigned v);
    logic [KEY_W-1:0] k;
    k = '0;
    for (int i = 0; i < KEY_DIGITS; i++) begin
      k[4*i +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return k;
  endfunction : key_bcd

  // one-cycle request; deferred ones rely on a later execute
  task automatic send(input cmd_code_e code, input logic [KEY_W-1:0] arg);
    @(posedge clk);
    #1;
    cmd = '{1'b1, code, arg};
    @(posedge clk);
    #1;
    cmd = '{1'b0, CMD_NONE, ~arg};  // released payload never repeats the last value
  endtask : send
endmodule : host_ctrl_model

// ### tb/recorder_system_command_handler_tb.sv
// self-checking bench of the recorder command handler
`timescale 1ns/100ps
module recorder_system_command_handler_tb;
  import cmd_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic                 clk = 1'b0;
  logic                 rst_n, cfg_wr, acq_configured, buf_wr, buf_rd;
  logic                 cal_protect_pin, err_clr;
  cmd_s                 cmd;
  cfg_s                 cfg_in;
  logic                 trig_start_p, trig_stop_p, acq_running, chan_configured;
  logic                 hll_en, buf_flush_p, cal_mode;
  logic [BUF_CNT_W-1:0] buf_count;
  logic [7:0]           poll_byte, cal_status, err_flags;
  cfg_s                 cfg_out;
  cal_src_s             cal_src;
  int                   failures = 0;
  int                   checks = 0;
  int                   cycles = 0;

  localparam cfg_s       CFG_USER = '{1'b1, 1'b1, 8'h40, 8'h0D};
  localparam cfg_s       CFG_STOP = '{1'b0, 1'b1, 8'h40, 8'h0D};
  localparam logic [7:0] SRC_ARGS [3] = '{SRC_NEG_ARG, SRC_POS_ARG, SRC_GND_ARG};

  always #12.5 clk = ~clk;

  host_ctrl_model i_host_ctrl_model (.clk(clk), .cmd(cmd));

  cmd_handler i_cmd_handler (
    .clk(clk), .rst_n(rst_n), .cmd_in(cmd), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .acq_configured(acq_configured), .buf_wr(buf_wr), .buf_rd(buf_rd),
    .cal_protect_pin(cal_protect_pin), .err_clr(err_clr),
    .trig_start_p(trig_start_p), .trig_stop_p(trig_stop_p), .acq_running(acq_running),
    .chan_configured(chan_configured), .high_low_last_values_en(hll_en),
    .buf_flush_p(buf_flush_p), .buf_count(buf_count), .poll_byte(poll_byte),
    .cfg_out(cfg_out), .cal_mode(cal_mode), .cal_status(cal_status),
    .cal_src(cal_src), .err_flags(err_flags)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick

  task automatic send(input cmd_code_e c, input logic [KEY_W-1:0] a = '0);
    i_host_ctrl_model.send(c, a);
  endtask : send

  task automatic clear_err;
    err_clr = 1'b1;
    tick();
    err_clr = 1'b0;
  endtask : clear_err

  task automatic load_cfg(input cfg_s c);
    cfg_wr = 1'b1;
    cfg_in = c;
    tick();
    cfg_wr = 1'b0;
  endtask : load_cfg

  task automatic results;
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_trigger;
    send(CMD_TRIG);
    check(err_flags, 8'h01);
    clear_err();
    send(CMD_EXECUTE);
    check(trig_start_p, 1'b0);
    load_cfg(CFG_USER);
    send(CMD_TRIG);
    check({trig_start_p, acq_running}, 2'h0);
    // two idle cycles before execute: nothing may start meanwhile
    tick();
    check({trig_start_p, acq_running}, 2'h0);
    send(CMD_EXECUTE);
    check({trig_start_p, trig_stop_p, acq_running}, 3'h5);
    tick();
    check(trig_start_p, 1'b0);
    send(CMD_TRIG);
    send(CMD_EXECUTE);
    check({trig_start_p, trig_stop_p, acq_running, err_flags}, 11'h200);
    // stop-only setup: trigger accepted, but idle cannot start
    load_cfg(CFG_STOP);
    send(CMD_TRIG);
    send(CMD_EXECUTE);
    check({trig_start_p, trig_stop_p, acq_running, err_flags}, 11'h000);
  endtask : t_trigger

  task automatic t_buffer;
    send(CMD_CHAN_CFG);
    buf_wr = 1'b1;
    tick(3);
    buf_wr = 1'b0;
    buf_rd = 1'b1;
    tick();
    buf_rd = 1'b0;
    check(buf_count, 11'h002);
    buf_wr = 1'b1;
    tick(BUF_DEPTH - 2);
    check({poll_byte, buf_count}, {8'h00, 11'h400});
    tick();
    check(poll_byte, 8'h80);
    // flush wins over a write in the same cycle
    send(CMD_FLUSH);
    buf_wr = 1'b0;
    check({buf_flush_p, poll_byte, buf_count}, {1'b1, 8'h00, 11'h000});
    tick();
    check(buf_flush_p, 1'b0);
  endtask : t_buffer

  task automatic t_chan_clear;
    buf_wr = 1'b1;
    tick();
    buf_wr = 1'b0;
    send(CMD_CLR_CHAN);
    check({chan_configured, hll_en}, 2'h3);
    send(CMD_EXECUTE);
    check({chan_configured, hll_en}, 2'h0);
    buf_wr = 1'b1;
    tick(2);
    buf_wr = 1'b0;
    check(buf_count, 11'h001);
    send(CMD_CHAN_CFG);
    check({chan_configured, hll_en}, 2'h3);
  endtask : t_chan_clear

  task automatic t_keyword;
    cal_protect_pin = 1'b1;
    tick(3);
    send(CMD_KEYWORD, i_host_ctrl_model.key_bcd(24680));
    check(err_flags, 8'h08);
    clear_err();
    send(CMD_CAL_ENTER, i_host_ctrl_model.key_bcd(24680));
    check({cal_mode, cal_status}, 9'h010);
    send(CMD_CAL_EXIT);
    cal_protect_pin = 1'b0;
    tick(3);
    send(CMD_KEYWORD, 20'h1234A);
    check(err_flags, 8'h04);
    clear_err();
    send(CMD_KEYWORD, i_host_ctrl_model.key_bcd(12345));
    check(err_flags, 8'h00);
    send(CMD_CAL_ENTER, 20'h12345);
    check({cal_mode, cal_status}, 9'h100);
    send(CMD_CAL_EXIT);
  endtask : t_keyword

  task automatic t_factory;
    load_cfg(CFG_USER);
    acq_configured = 1'b1;
    send(CMD_FACTORY);
    check({err_flags, cfg_out}, {8'h02, CFG_USER});
    acq_configured = 1'b0;
    clear_err();
    send(CMD_FACTORY);
    check({err_flags, cfg_out}, {8'h00, CFG_DEFAULT});
    // stored keyword survives the restore
    send(CMD_CAL_ENTER, 20'h12345);
    check(cal_mode, 1'b1);
  endtask : t_factory

  task automatic t_cal_src;
    for (int i = 0; i < 3; i++) begin
      send(CMD_CAL_SRC, {12'h000, SRC_ARGS[i]});
      check(cal_src, {3'h4 >> i, 1'b1});
    end
    send(CMD_CAL_SRC, 20'h00004);
    check(err_flags, 8'h10);
    send(CMD_CAL_EXIT);
    check({cal_mode, cal_src}, 5'h00);
  endtask : t_cal_src

  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  // ceiling well above the roughly 1100 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  initial begin
    {rst_n, cfg_wr, acq_configured, buf_wr, buf_rd, cal_protect_pin, err_clr} = '0;
    cfg_in = CFG_DEFAULT;
    tick(8);
    rst_n = 1'b1;
    check({err_flags, poll_byte, buf_count, acq_running, chan_configured}, '0);
    check(cfg_out, CFG_DEFAULT);
    t_trigger();
    t_buffer();
    t_chan_clear();
    t_keyword();
    t_factory();
    t_cal_src();
    results();
  end
endmodule : recorder_system_command_handler_tb
